// >>> isr_pkg.sv
// Shared constants and types for the I2C reset and ID slave pair
// Notes on behaviour
// - Two unassigned strap combinations never acknowledge an own address
// - Also answer general call and ID addresses
// - Reset call: START, then 00h write acknowledged
// - General call with read bit is refused
// - Command byte acknowledged only when 06h
// - Any further general call byte refused
// - STOP after accepted 06h gives soft reset
// - Repeated START after 06h cancels reset
// - Master treats any refusal as reset abort
// - Hardwired 24-bit ID: maker, part, revision
// - Master opens ID read with F8h write
// - Only the addressed slave acknowledges target byte
// - Master continues ID read with repeated START
// - STOP or foreign access drops ID read
// - ID sent maker, part, then revision last
// - Master refusal ends ID read, frees bus
// - Acknowledged reads past byte three wrap around
package isr_pkg;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [6:0] ID_ADDR = 7'h7c;
   localparam logic [7:0] GC_RESET_CMD = 8'h06;
   // Strap codes: 0 ground, 1 supply, 2 clock line, 3 data line
   localparam int STRAP_BUS_BIT = 1;
   localparam int STRAP_LVL_BIT = 0;
   // Address prefix, one nibble per pattern of bus-line straps {hi,mid,lo}
   localparam logic [31:0] PREFIX_TBL = 32'hd90f6187;
   // Identification fields; values are arbitrary
   localparam logic [7:0] ID_MAKER = 8'h5a;
   localparam logic [6:0] ID_CATEGORY = 7'h11;
   localparam logic [5:0] ID_FEATURE = 6'h22;
   localparam logic [2:0] ID_REVISION = 3'h1;
   localparam logic [23:0] ID_WORD = {ID_MAKER, ID_CATEGORY, ID_FEATURE, ID_REVISION};
   localparam logic [1:0] ID_LAST_BYTE = 2'h2;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Master bit timing: a quarter of a 1 MHz bus clock period, rounded up to whole cycles (7 cycles, 280 ns)
   localparam int CLK_FREQ_MHZ = 25;
   localparam int SCL_QTR_NS = 250;
   localparam int SCL_QTR_CYC = (SCL_QTR_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam logic [3:0] QTR_RELOAD = 4'(SCL_QTR_CYC - 1);
   // Master step indexes where the stop falls
   localparam logic [3:0] STEP_STOP_RST = 4'h3;
   localparam logic [3:0] STEP_STOP_ID = 4'h8;

   typedef enum logic [4:0] {
      D_IDLE = 5'b00001,
      D_RX = 5'b00010,
      D_ACK = 5'b00100,
      D_TX = 5'b01000,
      D_MACK = 5'b10000
   } isr_dst_e;

   typedef enum logic [2:0] {
      K_ADDR = 3'h0,
      K_GCCMD = 3'h1,
      K_GCXTRA = 3'h2,
      K_IDTGT = 3'h3,
      K_NONE = 3'h4
   } isr_kind_e;

   typedef enum logic [1:0] {
      M_IDLE = 2'b01,
      M_RUN = 2'b10
   } isr_mst_e;

   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_WR = 2'h1,
      OP_RD = 2'h2,
      OP_STOP = 2'h3
   } isr_op_e;

   typedef enum logic {
      CMD_SWRESET = 1'b0,
      CMD_READ_ID = 1'b1
   } isr_cmd_e;
endpackage

// >>> isr_bus_if.sv
// Open-drain I2C bus joining the master end and the slave end
`timescale 1ns/1ps
`default_nettype none
interface isr_bus_if;
   logic mst_scl_oe;
   logic mst_sda_oe;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // Wired-AND: a line is low while any party enables its driver
   assign scl = ~mst_scl_oe;
   assign sda = ~(mst_sda_oe | dev_sda_oe);

   modport dev (input scl, input sda, output dev_sda_oe);
   modport mst (input scl, input sda, output mst_scl_oe, output mst_sda_oe);
endinterface
`default_nettype wire

// >>> isr_dev.sv
// I2C slave end: strap address, software reset call and device ID read
`timescale 1ns/1ps
`default_nettype none
module isr_dev (
   input wire logic clk, // System clock, 25 MHz
   input wire logic reset, // Asynchronous reset, active high
   input wire logic [1:0] addr_strap_hi, // High strap connection code
   input wire logic [1:0] addr_strap_mid, // Middle strap connection code
   input wire logic [1:0] addr_strap_lo, // Low strap connection code
   isr_bus_if.dev bus, // I2C bus lines
   output logic sw_reset, // Pulse: return to power-up state
   output logic [6:0] own_addr, // Decoded own slave address
   output logic addr_valid // Strap combination owns an address
);
   logic [5:0] strap_s1;
   logic [5:0] strap_s2;
   logic scl_s1;
   logic scl_s2;
   logic scl_d;
   logic sda_s1;
   logic sda_s2;
   logic sda_d;
   logic start_c;
   logic stop_c;
   logic rise;
   logic fall;
   isr_pkg::isr_dst_e state;
   isr_pkg::isr_kind_e kind;
   logic [3:0] bcnt;
   logic [7:0] shreg;
   logic [7:0] txbyte;
   logic [1:0] id_idx;
   logic ack_go;
   logic go_tx;
   logic sda_oe;
   logic gc_ok;
   logic id_armed;
   logic [7:0] byte_in;
   logic byte_done;
   logic mack_nack;
   logic dec_ack;
   logic dec_tx;
   isr_pkg::isr_kind_e dec_kind;
   logic [6:0] strap_addr;
   logic [7:0] id_next;

   function automatic logic [6:0] strap_decode(input logic [5:0] s);
      logic [2:0] pat;
      pat = {s[4 + isr_pkg::STRAP_BUS_BIT], s[2 + isr_pkg::STRAP_BUS_BIT],
             s[isr_pkg::STRAP_BUS_BIT]};
      strap_decode = {isr_pkg::PREFIX_TBL[4 * pat +: 4], s[4 + isr_pkg::STRAP_LVL_BIT],
                      s[2 + isr_pkg::STRAP_LVL_BIT], s[isr_pkg::STRAP_LVL_BIT]};
   endfunction

   function automatic logic [7:0] id_byte(input logic [1:0] idx);
      case (idx)
         2'h0: id_byte = isr_pkg::ID_WORD[23:16];
         2'h1: id_byte = isr_pkg::ID_WORD[15:8];
         default: id_byte = isr_pkg::ID_WORD[7:0];
      endcase
   endfunction

   assign bus.dev_sda_oe = sda_oe;
   assign strap_addr = strap_decode(strap_s2);
   assign id_next = id_byte(id_idx);

   // Strap sampling and address decode
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         strap_s1 <= 6'h00;
         strap_s2 <= 6'h00;
         own_addr <= 7'h00;
         addr_valid <= 1'b0;
      end
      else
      begin
         strap_s1 <= {addr_strap_hi, addr_strap_mid, addr_strap_lo};
         strap_s2 <= strap_s1;
         own_addr <= strap_addr;
         addr_valid <= (strap_addr != isr_pkg::GC_ADDR) && (strap_addr != isr_pkg::ID_ADDR);
      end
   end

   // Bus line synchronisers and condition detection
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_s1 <= bus.scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   assign start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
   assign rise = scl_s2 & ~scl_d;
   assign fall = ~scl_s2 & scl_d;
   assign byte_in = {shreg[6:0], sda_s2};
   assign byte_done = (state == isr_pkg::D_RX) && rise && (bcnt == 4'h7);
   assign mack_nack = (state == isr_pkg::D_MACK) && rise && sda_s2;

   // Decision on a completed received byte
   always_comb
   begin
      dec_ack = 1'b0;
      dec_tx = 1'b0;
      dec_kind = isr_pkg::K_NONE;
      case (kind)
         isr_pkg::K_ADDR:
         begin
            if (byte_in == {isr_pkg::GC_ADDR, 1'b0})
            begin
               dec_ack = 1'b1;
               dec_kind = isr_pkg::K_GCCMD;
            end
            else if (byte_in == {isr_pkg::ID_ADDR, 1'b0})
            begin
               dec_ack = 1'b1;
               dec_kind = isr_pkg::K_IDTGT;
            end
            else if (byte_in == {isr_pkg::ID_ADDR, 1'b1})
            begin
               dec_ack = id_armed;
               dec_tx = id_armed;
            end
            else if (addr_valid && (byte_in[7:1] == own_addr))
               dec_ack = 1'b1;
         end
         isr_pkg::K_GCCMD:
         begin
            if (byte_in == isr_pkg::GC_RESET_CMD)
            begin
               dec_ack = 1'b1;
               dec_kind = isr_pkg::K_GCXTRA;
            end
         end
         isr_pkg::K_IDTGT:
            dec_ack = addr_valid && (byte_in[7:1] == own_addr);
         default:
            dec_ack = 1'b0;
      endcase
   end

   // Byte engine: receive, acknowledge, transmit ID, take master acknowledge
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state <= isr_pkg::D_IDLE;
         kind <= isr_pkg::K_NONE;
         bcnt <= 4'h0;
         shreg <= 8'h00;
         txbyte <= 8'h00;
         id_idx <= 2'h0;
         ack_go <= 1'b0;
         go_tx <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (start_c)
      begin
         state <= isr_pkg::D_RX;
         kind <= isr_pkg::K_ADDR;
         bcnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (stop_c)
      begin
         state <= isr_pkg::D_IDLE;
         sda_oe <= 1'b0;
      end
      else
      begin
         unique case (state)
            isr_pkg::D_IDLE:
               sda_oe <= 1'b0;
            isr_pkg::D_RX:
            begin
               if (rise)
               begin
                  shreg <= byte_in;
                  bcnt <= bcnt + 4'h1;
                  if (bcnt == 4'h7)
                  begin
                     ack_go <= dec_ack;
                     go_tx <= dec_tx;
                     kind <= dec_kind;
                  end
               end
               else if (fall && (bcnt == isr_pkg::BYTE_BITS))
               begin
                  sda_oe <= ack_go;
                  state <= ack_go ? isr_pkg::D_ACK : isr_pkg::D_IDLE;
               end
            end
            isr_pkg::D_ACK:
            begin
               if (fall)
               begin
                  bcnt <= 4'h0;
                  if (go_tx)
                  begin
                     id_idx <= 2'h0;
                     txbyte <= {isr_pkg::ID_WORD[22:16], 1'b0};
                     sda_oe <= ~isr_pkg::ID_WORD[23];
                     state <= isr_pkg::D_TX;
                  end
                  else
                  begin
                     sda_oe <= 1'b0;
                     state <= (kind == isr_pkg::K_NONE) ? isr_pkg::D_IDLE : isr_pkg::D_RX;
                  end
               end
            end
            isr_pkg::D_TX:
            begin
               if (rise)
                  bcnt <= bcnt + 4'h1;
               else if (fall)
               begin
                  if (bcnt == isr_pkg::BYTE_BITS)
                  begin
                     sda_oe <= 1'b0;
                     state <= isr_pkg::D_MACK;
                  end
                  else
                  begin
                     sda_oe <= ~txbyte[7];
                     txbyte <= {txbyte[6:0], 1'b0};
                  end
               end
            end
            isr_pkg::D_MACK:
            begin
               if (rise)
               begin
                  ack_go <= ~sda_s2;
                  if (sda_s2)
                     state <= isr_pkg::D_IDLE;
                  else
                     id_idx <= (id_idx == isr_pkg::ID_LAST_BYTE) ? 2'h0 : id_idx + 2'h1;
               end
               else if (fall && ack_go)
               begin
                  bcnt <= 4'h0;
                  txbyte <= {id_next[6:0], 1'b0};
                  sda_oe <= ~id_next[7];
                  state <= isr_pkg::D_TX;
               end
            end
         endcase
      end
   end

   // Reset call arming and ID read arming
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         gc_ok <= 1'b0;
         id_armed <= 1'b0;
         sw_reset <= 1'b0;
      end
      else
      begin
         sw_reset <= stop_c & gc_ok;
         if (stop_c)
         begin
            gc_ok <= 1'b0;
            id_armed <= 1'b0;
         end
         else if (start_c)
            gc_ok <= 1'b0;
         else if (mack_nack)
            id_armed <= 1'b0;
         else if (byte_done)
         begin
            unique case (kind)
               isr_pkg::K_GCCMD:
                  gc_ok <= dec_ack;
               isr_pkg::K_GCXTRA:
                  gc_ok <= 1'b0;
               isr_pkg::K_IDTGT:
                  id_armed <= dec_ack;
               isr_pkg::K_ADDR:
                  id_armed <= id_armed && (byte_in == {isr_pkg::ID_ADDR, 1'b1});
               default:
                  gc_ok <= gc_ok;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// >>> isr_mst.sv
// I2C master end: issues the software reset call and the device ID read
`timescale 1ns/1ps
`default_nettype none
module isr_mst (
   input wire logic clk, // System clock, 25 MHz
   input wire logic reset, // Asynchronous reset, active high
   isr_bus_if.mst bus, // I2C bus lines
   input wire logic cmd_valid, // Request a sequence
   input wire isr_pkg::isr_cmd_e cmd_kind, // Sequence to run
   input wire logic [6:0] cmd_target, // Slave to identify
   output logic busy, // Sequence in progress
   output logic done, // Pulse at sequence end
   output logic ok, // Last sequence fully acknowledged
   output logic [23:0] id_word // Identification read back
);
   isr_pkg::isr_mst_e state;
   isr_pkg::isr_cmd_e cmd;
   logic [6:0] tgt;
   logic [3:0] step;
   logic [3:0] tmr;
   logic [1:0] q;
   logic [3:0] bitn;
   logic err;
   logic scl_oe;
   logic sda_oe;
   logic sda_s1;
   logic sda_s2;
   logic tick;
   isr_pkg::isr_op_e op;
   logic [7:0] obyte;
   logic drv_bit;

   assign bus.mst_scl_oe = scl_oe;
   assign bus.mst_sda_oe = sda_oe;
   assign tick = (state == isr_pkg::M_RUN) && (tmr == 4'h0);

   // Step program of each sequence
   always_comb
   begin
      op = isr_pkg::OP_STOP;
      obyte = 8'h00;
      if (cmd == isr_pkg::CMD_SWRESET)
      begin
         unique case (step)
            4'h0: op = isr_pkg::OP_START;
            4'h1: op = isr_pkg::OP_WR;
            4'h2:
            begin
               op = isr_pkg::OP_WR;
               obyte = isr_pkg::GC_RESET_CMD;
            end
            default: op = isr_pkg::OP_STOP;
         endcase
      end
      else
      begin
         unique case (step)
            4'h0, 4'h3: op = isr_pkg::OP_START;
            4'h1:
            begin
               op = isr_pkg::OP_WR;
               obyte = {isr_pkg::ID_ADDR, 1'b0};
            end
            4'h2:
            begin
               op = isr_pkg::OP_WR;
               obyte = {tgt, 1'b0};
            end
            4'h4:
            begin
               op = isr_pkg::OP_WR;
               obyte = {isr_pkg::ID_ADDR, 1'b1};
            end
            4'h5, 4'h6: op = isr_pkg::OP_RD;
            4'h7:
            begin
               op = isr_pkg::OP_RD;
               obyte = 8'h01;
            end
            default: op = isr_pkg::OP_STOP;
         endcase
      end
   end

   assign drv_bit = (op == isr_pkg::OP_WR) ? ((bitn < isr_pkg::BYTE_BITS) && ~obyte[3'd7 - bitn[2:0]])
                                           : ((bitn == isr_pkg::BYTE_BITS) && ~obyte[0]);

   // Data line synchroniser
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end
      else
      begin
         sda_s1 <= bus.sda;
         sda_s2 <= sda_s1;
      end
   end

   // Sequencer: one action per quarter of a bus clock period
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state <= isr_pkg::M_IDLE;
         cmd <= isr_pkg::CMD_SWRESET;
         tgt <= 7'h00;
         step <= 4'h0;
         tmr <= 4'h0;
         q <= 2'h0;
         bitn <= 4'h0;
         err <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         ok <= 1'b0;
         id_word <= 24'h000000;
      end
      else
      begin
         done <= 1'b0;
         tmr <= (tmr == 4'h0) ? isr_pkg::QTR_RELOAD : tmr - 4'h1;
         unique case (state)
            isr_pkg::M_IDLE:
            begin
               if (cmd_valid)
               begin
                  state <= isr_pkg::M_RUN;
                  cmd <= cmd_kind;
                  tgt <= cmd_target;
                  step <= 4'h0;
                  q <= 2'h0;
                  bitn <= 4'h0;
                  err <= 1'b0;
                  busy <= 1'b1;
                  tmr <= isr_pkg::QTR_RELOAD;
                  id_word <= 24'h000000;
               end
            end
            isr_pkg::M_RUN:
            begin
               if (tick)
               begin
                  q <= q + 2'h1;
                  unique case (op)
                     isr_pkg::OP_START:
                     begin
                        if (q == 2'h0)
                           sda_oe <= 1'b0;
                        else if (q == 2'h1)
                           scl_oe <= 1'b0;
                        else if (q == 2'h2)
                           sda_oe <= 1'b1;
                        else
                        begin
                           scl_oe <= 1'b1;
                           step <= step + 4'h1;
                        end
                     end
                     isr_pkg::OP_STOP:
                     begin
                        if (q == 2'h0)
                           sda_oe <= 1'b1;
                        else if (q == 2'h1)
                           scl_oe <= 1'b0;
                        else if (q == 2'h2)
                           sda_oe <= 1'b0;
                        else
                        begin
                           state <= isr_pkg::M_IDLE;
                           busy <= 1'b0;
                           done <= 1'b1;
                           ok <= ~err;
                        end
                     end
                     default:
                     begin
                        if (q == 2'h0)
                           sda_oe <= drv_bit;
                        else if (q == 2'h1)
                           scl_oe <= 1'b0;
                        else if (q == 2'h2)
                        begin
                           if ((op == isr_pkg::OP_WR) && (bitn == isr_pkg::BYTE_BITS) && sda_s2)
                              err <= 1'b1;
                           if ((op == isr_pkg::OP_RD) && (bitn < isr_pkg::BYTE_BITS))
                              id_word <= {id_word[22:0], sda_s2};
                        end
                        else
                        begin
                           scl_oe <= 1'b1;
                           if (bitn == isr_pkg::BYTE_BITS)
                           begin
                              bitn <= 4'h0;
                              if (err)
                                 step <= (cmd == isr_pkg::CMD_SWRESET) ? isr_pkg::STEP_STOP_RST
                                                                      : isr_pkg::STEP_STOP_ID;
                              else
                                 step <= step + 4'h1;
                           end
                           else
                              bitn <= bitn + 4'h1;
                        end
                     end
                  endcase
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> isr_asserts.sv
// Wire-level checks on the I2C lines joining the two ends
`timescale 1ns/1ps
`default_nettype none
module isr_asserts (
   input wire logic clk, // Clock
   input wire logic reset, // Async reset
   input wire logic mst_scl_oe, // Master pulls SCL
   input wire logic mst_sda_oe, // Master pulls SDA
   input wire logic dev_sda_oe, // Slave pulls SDA
   input wire logic scl, // Clock line
   input wire logic sda // Data line
);
   logic [5:0] hi_cnt;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   // Cycles that SCL has stood high, saturating
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         hi_cnt <= 6'h00;
      end
      else
      begin
         hi_cnt <= !scl ? 6'h00 : hi_cnt + 6'(hi_cnt != 6'h3f);
      end
   end
   property p_idle_rst; $fell(reset) |-> (scl && sda && !dev_sda_oe) [*3]; endproperty
   a_idle_rst: assert property (p_idle_rst) else $error("bus busy after reset");
   property p_no_fight; scl |-> !(dev_sda_oe && mst_sda_oe); endproperty
   a_no_fight: assert property (p_no_fight) else $error("both drive SDA");
   property p_dev_hold; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("slave SDA moved");
   property p_dev_lag; $rose(dev_sda_oe) |-> !scl && !$past(scl); endproperty
   a_dev_lag: assert property (p_dev_lag) else $error("slave drive early");
   property p_scl_high; $rose(scl) |-> scl [*8]; endproperty
   a_scl_high: assert property (p_scl_high) else $error("SCL high short");
   property p_scl_low; $rose(mst_scl_oe) |-> mst_scl_oe [*8] ##[1:12] !mst_scl_oe; endproperty
   a_scl_low: assert property (p_scl_low) else $error("SCL low length");
   property p_sda_ctrl; scl && $past(scl) && $changed(sda) |-> $changed(mst_sda_oe); endproperty
   a_sda_ctrl: assert property (p_sda_ctrl) else $error("SDA moved by slave");
   property p_dev_idle; hi_cnt > 6'h1d |-> !dev_sda_oe; endproperty
   a_dev_idle: assert property (p_dev_idle) else $error("slave holds idle bus");
   c_start: cover property (scl && $past(scl) && $fell(sda));
   c_stop: cover property (scl && $past(scl) && $rose(sda));
   c_ack: cover property (scl && dev_sda_oe && !mst_sda_oe);
endmodule
`default_nettype wire

// >>> isr_tb_top.sv
// Bench: master end runs reset calls and ID reads against the slave end
`timescale 1ns/1ps
`default_nettype none
module isr_tb_top;
   logic clk;
   logic reset;
   logic [1:0] addr_strap_hi;
   logic [1:0] addr_strap_mid;
   logic [1:0] addr_strap_lo;
   logic sw_reset;
   logic [6:0] own_addr;
   logic addr_valid;
   logic cmd_valid;
   isr_pkg::isr_cmd_e cmd_kind;
   logic [6:0] cmd_target;
   logic busy;
   logic done;
   logic ok;
   logic [23:0] id_word;
   int fail_count = 0;
   int samples_checked = 0;
   int swr_cnt = 0;
   int base;
   // Strap code {hi,mid,lo}, owns an address, target address
   logic [13:0] rows [8] = '{{6'h2a, 1'h1, 7'h68}, {6'h20, 1'h1, 7'h78},
      {6'h35, 1'h1, 7'h7f}, {6'h27, 1'h1, 7'h03}, {6'h00, 1'h1, 7'h38},
      {6'h08, 1'h1, 7'h08}, {6'h30, 1'h0, 7'h7c}, {6'h22, 1'h0, 7'h01}};

   isr_bus_if isr_bus_if_inst ();
   isr_dev isr_dev_inst (.clk, .reset, .addr_strap_hi, .addr_strap_mid, .addr_strap_lo,
      .bus(isr_bus_if_inst.dev), .sw_reset, .own_addr, .addr_valid);
   isr_mst isr_mst_inst (.clk, .reset, .bus(isr_bus_if_inst.mst), .cmd_valid, .cmd_kind,
      .cmd_target, .busy, .done, .ok, .id_word);
   isr_asserts isr_asserts_inst (.clk, .reset, .mst_scl_oe(isr_bus_if_inst.mst_scl_oe),
      .mst_sda_oe(isr_bus_if_inst.mst_sda_oe), .dev_sda_oe(isr_bus_if_inst.dev_sda_oe),
      .scl(isr_bus_if_inst.scl), .sda(isr_bus_if_inst.sda));

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) if (sw_reset === 1'b1) swr_cnt++;

   task chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (done !== 1'b1 && n < 4000);
      chk("done", 24'h1, 24'(done));
   endtask

   task issue(input isr_pkg::isr_cmd_e k, input logic [6:0] t);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_target = t;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask

   task run(input isr_pkg::isr_cmd_e k, input logic [6:0] t);
      issue(k, t);
      wait_done();
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial
   begin
      reset = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = isr_pkg::CMD_SWRESET;
      cmd_target = 7'h00;
      {addr_strap_hi, addr_strap_mid, addr_strap_lo} = 6'h2a;
      repeat (2) @(negedge clk);
      chk("busy", 24'h0, 24'(busy));
      chk("id_word", 24'h0, id_word);
      chk("sda", 24'h1, 24'(isr_bus_if_inst.sda));
      reset = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         {addr_strap_hi, addr_strap_mid, addr_strap_lo} = rows[i][13:8];
         repeat (5) @(negedge clk);
         base = swr_cnt;
         chk("addr_valid", 24'(rows[i][7]), 24'(addr_valid));
         if (rows[i][7]) chk("own_addr", 24'(rows[i][6:0]), 24'(own_addr));
         run(isr_pkg::CMD_READ_ID, rows[i][6:0]);
         chk("id_ok", 24'(rows[i][7]), 24'(ok));
         if (rows[i][7]) chk("id", isr_pkg::ID_WORD, id_word);
         run(isr_pkg::CMD_SWRESET, 7'h00);
         repeat (20) @(negedge clk);
         chk("rst_ok", 24'h1, 24'(ok));
         chk("sw_reset", 24'h1, 24'(swr_cnt - base));
      end
      {addr_strap_hi, addr_strap_mid, addr_strap_lo} = 6'h2a;
      repeat (5) @(negedge clk);
      base = swr_cnt;
      run(isr_pkg::CMD_READ_ID, 7'h69);
      chk("wrong_ok", 24'h0, 24'(ok));
      // Back to back; a new kind while busy must not disturb the read
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_kind = isr_pkg::CMD_READ_ID;
      cmd_target = 7'h68;
      @(negedge clk);
      cmd_kind = isr_pkg::CMD_SWRESET;
      chk("busy", 24'h1, 24'(busy));
      wait_done();
      chk("b2b_id", isr_pkg::ID_WORD, id_word);
      wait_done();
      cmd_valid = 1'b0;
      repeat (20) @(negedge clk);
      chk("b2b_ok", 24'h1, 24'(ok));
      chk("b2b_rst", 24'h1, 24'(swr_cnt - base));
      // Reset in mid transfer, then a clean read
      issue(isr_pkg::CMD_READ_ID, 7'h68);
      repeat (300) @(negedge clk);
      reset = 1'b1;
      @(negedge clk);
      chk("rst_busy", 24'h0, 24'(busy));
      chk("rst_scl", 24'h1, 24'(isr_bus_if_inst.scl));
      reset = 1'b0;
      repeat (5) @(negedge clk);
      run(isr_pkg::CMD_READ_ID, 7'h68);
      chk("re_id", isr_pkg::ID_WORD, id_word);
      summarize();
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      fail_count++;
      summarize();
   end
endmodule
`default_nettype wire
